// file: design/can_ctrl_core.sv
// CAN controller core: bit timing, enable control, error counters, interrupts.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module can_ctrl_core
  import can_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic can_rx,
  input wire evt_t evt,
  output logic proc_active,
  output logic tq_tick,
  output logic bit_start,
  output logic sample_point,
  output logic irq
);
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFF_INT_CLR;
  endfunction : mapped

  // Write and read channel holding.
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go, rd_go;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl, wr_btr, wr_intid, wr_xfer, wr_en, wr_clr, rd_status;
  assign wr_ctrl = wr_go && awaddr_q == OFF_CTRL;
  assign wr_btr = wr_go && awaddr_q == OFF_BTR;
  assign wr_intid = wr_go && awaddr_q == OFF_INTID;
  assign wr_xfer = wr_go && awaddr_q == OFF_OBJXFER;
  assign wr_en = wr_go && awaddr_q == OFF_INT_EN;
  assign wr_clr = wr_go && awaddr_q == OFF_INT_CLR;
  assign rd_status = rd_go && s_axi_araddr == OFF_STATUS;

  // Control state: leaving ACTIVE keeps configuration and error counters; the quantum and bit counters are cleared.
  logic [31:0] ctrl_q;
  ctl_state_t state_q;
  logic busoff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 32'h0000_0000;
    end else if (wr_ctrl) begin
      ctrl_q <= merge_strb(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0003;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (ctrl_q[CTRL_RUN]) state_q <= ST_ACTIVE;
        ST_ACTIVE: begin
          if (busoff) state_q <= ST_OFFBUS;
          else if (!ctrl_q[CTRL_RUN]) state_q <= ST_IDLE;
        end
        ST_OFFBUS: if (!ctrl_q[CTRL_RUN]) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign proc_active = state_q == ST_ACTIVE;

  // Bit timing register, locked while processing runs.
  btr_t btr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btr_q <= btr_t'(BTR_RESET);
    end else if (wr_btr && state_q != ST_ACTIVE) begin
      btr_q <= btr_t'(merge_strb(btr_q, wdata_q, wstrb_q) & 32'h03FF_03FF);
    end
  end

  // Receive pin synchroniser and falling edge detect on synchronised data.
  logic rx_meta_q, rx_sync_q, rx_last_q, rx_fall;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_last_q <= 1'b1;
    end else begin
      rx_meta_q <= can_rx;
      rx_sync_q <= rx_meta_q;
      rx_last_q <= rx_sync_q;
    end
  end
  assign rx_fall = rx_last_q && !rx_sync_q;

  // Quantum prescaler; a divisor of 0 acts as 1.
  logic [9:0] qcnt_q, div_m1;
  logic q_en;
  assign div_m1 = (btr_q.quantum_clock_divisor == 10'h000) ? 10'h000 :
                  btr_q.quantum_clock_divisor - 10'h001;
  assign q_en = proc_active && qcnt_q >= div_m1;
  always_ff @(posedge aclk) begin
    if (!aresetn || !proc_active || q_en) begin
      qcnt_q <= 10'h000;
    end else begin
      qcnt_q <= qcnt_q + 10'h001;
    end
  end
  assign tq_tick = q_en;

  // Bit counter: quantum 0 is the sync segment, then first and second phase.
  logic [5:0] bcnt_q, ps1, last_q, sjw;
  logic [2:0] lng_q, shr_q;
  logic resynced_q, bit_end;
  assign ps1 = {2'b00, btr_q.prop_and_first_phase_quanta};
  assign sjw = {3'b000, 1'b0, btr_q.resync_jump_width} + 6'h01;
  assign last_q = ps1 + {2'b00, btr_q.second_phase_quanta} + {3'b000, lng_q}
                  - {3'b000, shr_q};
  assign bit_end = q_en && bcnt_q >= last_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !proc_active) begin
      bcnt_q <= 6'h00;
      lng_q <= 3'h0;
      shr_q <= 3'h0;
      resynced_q <= 1'b0;
    end else if (bit_end) begin
      bcnt_q <= 6'h00;
      lng_q <= 3'h0;
      shr_q <= 3'h0;
      resynced_q <= 1'b0;
    end else begin
      if (q_en) bcnt_q <= bcnt_q + 6'h01;
      if (rx_fall && !resynced_q && bcnt_q != 6'h00) begin
        resynced_q <= 1'b1;
        if (bcnt_q <= ps1) begin
          lng_q <= (bcnt_q < sjw) ? bcnt_q[2:0] : sjw[2:0];
        end else if (last_q - bcnt_q < sjw) begin
          shr_q <= 3'(last_q - bcnt_q);
        end else begin
          shr_q <= sjw[2:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_start <= 1'b0;
      sample_point <= 1'b0;
    end else begin
      bit_start <= bit_end;
      sample_point <= q_en && bcnt_q == ps1 + {3'b000, lng_q};
    end
  end

  // Error counters; events count only while processing runs.
  logic [7:0] tec_q;
  logic [7:0] rec_q;
  logic [8:0] tec_next;
  evt_t ev;
  assign ev = proc_active ? evt : '0;
  assign tec_next = {1'b0, tec_q} + {1'b0, TX_ERR_STEP};
  assign busoff = ev.tx_err && tec_next[8];
  always_ff @(posedge aclk) begin
    if (!aresetn || (state_q == ST_OFFBUS && !ctrl_q[CTRL_RUN])) begin
      tec_q <= 8'h00;
      rec_q <= 8'h00;
    end else begin
      if (ev.tx_err) tec_q <= tec_next[8] ? 8'hFF : tec_next[7:0];
      else if (ev.tx_ok && tec_q != 8'h00) tec_q <= tec_q - 8'h01;
      if (ev.rx_err && rec_q != 8'hFF) rec_q <= rec_q + 8'h01;
      else if (ev.rx_ok && rec_q != 8'h00) rec_q <= rec_q - 8'h01;
    end
  end
  logic epass, ewarn, lim_q;
  assign epass = rec_q >= EPASS_LIMIT || tec_q >= EPASS_LIMIT;
  assign ewarn = rec_q >= EWARN_LIMIT || tec_q >= EWARN_LIMIT;
  always_ff @(posedge aclk) begin
    if (!aresetn) lim_q <= 1'b0;
    else lim_q <= ewarn;
  end

  // Success flags survive until the status read; a new event wins.
  logic tx_ok_q, rx_ok_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ok_q <= 1'b0;
      rx_ok_q <= 1'b0;
    end else begin
      tx_ok_q <= ev.tx_ok || (tx_ok_q && !rd_status);
      rx_ok_q <= ev.rx_ok || (rx_ok_q && !rd_status);
    end
  end

  // Interrupt sources: status, error, per-object pending.
  logic [2:0] ist_q, ien_q;
  logic [31:0] opend_q, obj_set, obj_clr;
  logic st_evt, er_evt, st_clr;
  assign st_evt = ev.tx_ok || ev.rx_ok || ev.tx_err || ev.rx_err;
  assign er_evt = busoff || (ewarn && !lim_q);
  assign st_clr = rd_status || (wr_intid && wdata_q[15:0] == STATUS_INT_CODE) ||
                  (wr_clr && wdata_q[INT_STATUS]);
  assign obj_set = ev.obj ? 32'h0000_0001 << ev.obj_num : 32'h0000_0000;
  always_comb begin
    obj_clr = 32'h0000_0000;
    if (wr_intid && wdata_q[15:0] >= 16'h0001 && wdata_q[15:0] <= 16'h0020) begin
      obj_clr = 32'h0000_0001 << (wdata_q[4:0] - 5'h01);
    end
    if (wr_xfer && wdata_q[5:0] >= 6'h01 && wdata_q[5:0] <= 6'h20) begin
      obj_clr = obj_clr | (32'h0000_0001 << (wdata_q[4:0] - 5'h01));
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= 3'h0;
      opend_q <= 32'h0000_0000;
    end else begin
      ist_q[INT_STATUS] <= st_evt || (ist_q[INT_STATUS] && !st_clr);
      ist_q[INT_ERROR] <= er_evt || (ist_q[INT_ERROR] && !(wr_clr && wdata_q[INT_ERROR]));
      opend_q <= obj_set | (opend_q & ~obj_clr);
      ist_q[INT_OBJECT] <= |(obj_set | (opend_q & ~obj_clr));
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ien_q <= 3'h0;
    else if (wr_en) ien_q <= wdata_q[2:0];
  end
  logic [2:0] src;
  assign src = {ist_q[INT_OBJECT], ist_q[INT_ERROR], ist_q[INT_STATUS]};
  assign irq = ctrl_q[CTRL_MASTER] && |(src & ien_q);

  // Interrupt identifier: status first, then lowest object number.
  logic [15:0] intid;
  always_comb begin
    intid = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      if (opend_q[i]) intid = 16'(i + 1);
    end
    if (ist_q[INT_STATUS]) intid = STATUS_INT_CODE;
  end

  // Read data path.
  logic [31:0] rmux;
  always_comb begin
    case (s_axi_araddr)
      OFF_CTRL: rmux = ctrl_q;
      OFF_BTR: rmux = btr_q;
      OFF_STATUS: rmux = {24'h000000, busoff || state_q == ST_OFFBUS, ewarn, epass,
                          rx_ok_q, tx_ok_q, 3'h0};
      OFF_ERRCNT: rmux = {16'h0000, rec_q >= EPASS_LIMIT, rec_q[6:0], tec_q};
      OFF_INTID: rmux = {16'h0000, intid};
      OFF_OBJPEND: rmux = opend_q;
      OFF_INT_STAT: rmux = {29'h0, src};
      OFF_INT_EN: rmux = {29'h0, ien_q};
      default: rmux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks.
  sequence s_status_read;
    rd_status && !st_evt;
  endsequence
  sequence s_xfer(int n);
    wr_xfer && wdata_q[5:0] == 6'(n) && !(ev.obj && ev.obj_num == 5'(n - 1));
  endsequence
  a_irq_master_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[CTRL_MASTER] |-> !irq) else $error("irq without global enable");
  a_irq_src_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> |(src & ien_q)) else $error("irq from a disabled source");
  a_reset_idle: assert property (@(posedge aclk)
    !aresetn |=> !proc_active && !bit_start) else $error("active after reset");
  a_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !proc_active |=> !sample_point && !bit_start) else $error("bit activity while idle");
  a_btr_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_btr && proc_active |=> $stable(btr_q)) else $error("timing changed while active");
  a_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_status_read |=> !ist_q[INT_STATUS]) else $error("status interrupt survived read");
  a_xfer_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_xfer(1) |=> !opend_q[0]) else $error("object 1 pending after transfer");
  a_epass_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && s_axi_araddr == OFF_ERRCNT |=> s_axi_rdata[EC_PASSIVE_BIT] == $past(rec_q[7]))
    else $error("passive flag wrong");
  a_quantum_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    q_en && div_m1 == 10'h001 |=> !q_en ##1 (q_en || !proc_active))
    else $error("quantum period wrong for divisor 2");
  a_bit_length: assert property (@(posedge aclk) disable iff (!aresetn)
    bit_end && lng_q == 3'h0 && shr_q == 3'h0
    |-> bcnt_q == ps1 + {2'b00, btr_q.second_phase_quanta}) else $error("bit length wrong");
endmodule : can_ctrl_core

// file: design/can_ctrl_pkg.sv
// Shared constants and types for the CAN controller core.
package can_ctrl_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BTR = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_ERRCNT = 8'h0C;
  localparam logic [7:0] OFF_INTID = 8'h10;
  localparam logic [7:0] OFF_OBJPEND = 8'h14;
  localparam logic [7:0] OFF_OBJXFER = 8'h18;
  localparam logic [7:0] OFF_INT_STAT = 8'h1C;
  localparam logic [7:0] OFF_INT_EN = 8'h20;
  localparam logic [7:0] OFF_INT_CLR = 8'h24;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int INT_STATUS = 0;
  localparam int INT_ERROR = 1;
  localparam int INT_OBJECT = 2;
  localparam int ST_TX_OK = 3;
  localparam int ST_RX_OK = 4;
  localparam int ST_EPASS = 5;
  localparam int ST_EWARN = 6;
  localparam int ST_BUSOFF = 7;
  localparam int EC_PASSIVE_BIT = 15;
  localparam logic [15:0] STATUS_INT_CODE = 16'h8000;
  localparam logic [31:0] BTR_RESET = 32'h0013_0001;
  localparam logic [7:0] EWARN_LIMIT = 8'h60;
  localparam logic [7:0] EPASS_LIMIT = 8'h80;
  localparam logic [7:0] TX_ERR_STEP = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Bit timing register: phase quanta counts are used as written; the jump width is the field plus one.
  typedef struct packed {
    logic [5:0] rsvd;
    logic [1:0] resync_jump_width;
    logic [3:0] second_phase_quanta;
    logic [3:0] prop_and_first_phase_quanta;
    logic [5:0] rsvd_lo;
    logic [9:0] quantum_clock_divisor;
  } btr_t;
  typedef struct packed {
    logic tx_ok;
    logic rx_ok;
    logic tx_err;
    logic rx_err;
    logic obj;
    logic [4:0] obj_num;
  } evt_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_OFFBUS = 2'b11
  } ctl_state_t;
endpackage : can_ctrl_pkg

// file: verification/can_bus_node.sv
// Behavioural model of another node driving traffic onto the shared bus.
`timescale 1ns/1ps
module can_bus_node (
  input wire logic aclk,
  input wire logic talk,
  output logic can_rx
);
  logic [7:0] lfsr_q = 8'hA5;
  logic [4:0] hold_q = 5'h0;
  initial can_rx = 1'b1;
  // While talk is low the bus rests recessive; bit lengths vary from short to long.
  always @(posedge aclk) begin
    if (!talk) begin
      can_rx <= 1'b1;
      hold_q <= 5'h0;
    end else if (hold_q == 5'h0) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      can_rx <= lfsr_q[0];
      hold_q <= {lfsr_q[3:1], 2'h3};
    end else begin
      hold_q <= hold_q - 5'h1;
    end
  end
endmodule : can_bus_node

// file: verification/test_can_ctrl_core.sv
// Self-checking bench for the CAN controller core.
`timescale 1ns/1ps
module test_can_ctrl_core
  import can_ctrl_pkg::*;
;
  logic aclk, aresetn, can_rx, proc_active, tq_tick, bit_start, sample_point, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  evt_t evt;
  logic talk;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  integer seed = 32'h6F424FF9;

  can_ctrl_core uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .can_rx(can_rx), .evt(evt), .proc_active(proc_active),
    .tq_tick(tq_tick), .bit_start(bit_start), .sample_point(sample_point), .irq(irq));
  can_bus_node peer (.aclk(aclk), .talk(talk), .can_rx(can_rx));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task summarize;
    $display("mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      summarize();
    end
  end

  // Waits for a falling edge, then compares the value that was passed when the task was called.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    @(negedge aclk);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er = RESP_OKAY);
    logic aw_d, w_d;
    logic [1:0] r;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw_d = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_d = 1'b1;
      @(posedge aclk);
      if (aw_d) s_axi_awvalid <= 1'b0;
      if (w_d) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask : axi_rd

  task automatic pulse(input evt_t e);
    @(posedge aclk);
    evt <= e;
    @(posedge aclk);
    evt <= '0;
    // Ends on a falling edge so that callers see the registered effect of the event.
    @(negedge aclk);
  endtask : pulse

  // Counts clocks, quanta and the sample point offset across one whole bit.
  task automatic meas(output int nclk, output int ntq, output int nsp);
    nclk = 0;
    ntq = 0;
    nsp = 0;
    do @(negedge aclk); while (!bit_start);
    do begin
      @(negedge aclk);
      nclk++;
      if (tq_tick) ntq++;
      if (sample_point) nsp = nclk;
    end while (!bit_start);
  endtask : meas

  function automatic int divisor(input btr_t b);
    return (b.quantum_clock_divisor == 10'h0) ? 1 : int'(b.quantum_clock_divisor);
  endfunction : divisor

  function automatic int quanta(input btr_t b);
    return int'(b.prop_and_first_phase_quanta) + int'(b.second_phase_quanta) + 1;
  endfunction : quanta

  function automatic int jump(input btr_t b);
    return int'(b.resync_jump_width) + 1;
  endfunction : jump

  initial begin
    btr_t b;
    int nclk, ntq, nsp, n;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    evt = '0;
    talk = 1'b0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(proc_active, 1'b0);
    chk(irq, 1'b0);
    axi_rd(OFF_BTR, BTR_RESET);
    axi_rd(OFF_ERRCNT, 32'h0);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(8'h44, 32'hFFFF_FFFF, RESP_SLVERR);
    for (int i = 1; i <= 32; i++) axi_wr(OFF_INTID, 32'(i));
    for (int i = 0; i < 4; i++) begin
      b = '0;
      b.quantum_clock_divisor = 10'(1 + $unsigned($random(seed)) % 4);
      b.prop_and_first_phase_quanta = 4'(1 + $unsigned($random(seed)) % 8);
      b.second_phase_quanta = 4'(1 + $unsigned($random(seed)) % 8);
      b.resync_jump_width = 2'($random(seed));
      if (i == 0) begin
        b.quantum_clock_divisor = 10'h3FF;
        b.prop_and_first_phase_quanta = 4'h1;
        b.second_phase_quanta = 4'h1;
      end
      if (i == 1) b.quantum_clock_divisor = 10'h002;
      axi_wr(OFF_CTRL, 32'h0);
      axi_wr(OFF_BTR, b);
      axi_rd(OFF_BTR, b);
      axi_wr(OFF_CTRL, 32'h1);
      chk(proc_active, 1'b1);
      meas(nclk, ntq, nsp);
      chk(nclk, divisor(b) * quanta(b));
      chk(ntq, quanta(b));
      chk(nsp, divisor(b) * (1 + int'(b.prop_and_first_phase_quanta)));
      // A talking peer may resynchronise a bit by at most the jump width.
      talk <= 1'b1;
      meas(nclk, ntq, nsp);
      talk <= 1'b0;
      chk(nclk, divisor(b) * ntq);
      chk(ntq >= quanta(b) - jump(b) && ntq <= quanta(b) + jump(b), 1'b1);
      axi_wr(OFF_BTR, ~b);
      axi_rd(OFF_BTR, b);
    end
    axi_wr(OFF_CTRL, 32'h0);
    pulse(evt_t'{tx_ok: 1'b1, default: '0});
    pulse(evt_t'{obj: 1'b1, obj_num: 5'd3, default: '0});
    axi_rd(OFF_STATUS, 32'h0);
    axi_rd(OFF_OBJPEND, 32'h0);
    axi_wr(OFF_CTRL, 32'h1);
    axi_wr(OFF_INT_EN, 32'h1);
    pulse(evt_t'{tx_ok: 1'b1, default: '0});
    chk(irq, 1'b0);
    axi_rd(OFF_INTID, {16'h0, STATUS_INT_CODE});
    axi_wr(OFF_CTRL, 32'h3);
    chk(irq, 1'b1);
    axi_rd(OFF_STATUS, 32'h1 << ST_TX_OK);
    chk(irq, 1'b0);
    axi_rd(OFF_STATUS, 32'h0);
    pulse(evt_t'{rx_ok: 1'b1, default: '0});
    axi_wr(OFF_INTID, {16'h0, STATUS_INT_CODE});
    chk(irq, 1'b0);
    axi_rd(OFF_STATUS, 32'h1 << ST_RX_OK);
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 31 : int'($unsigned($random(seed)) % 32);
      pulse(evt_t'{obj: 1'b1, obj_num: 5'(n), default: '0});
      chk(irq, 1'b0);
      axi_rd(OFF_OBJPEND, 32'h1 << n);
      axi_rd(OFF_INTID, 32'(n + 1));
      axi_wr((i % 2 == 0) ? OFF_OBJXFER : OFF_INTID, 32'(n + 1));
      axi_rd(OFF_OBJPEND, 32'h0);
    end
    axi_wr(OFF_INT_EN, 32'h4);
    pulse(evt_t'{obj: 1'b1, obj_num: 5'd9, default: '0});
    chk(irq, 1'b1);
    axi_wr(OFF_OBJXFER, 32'd10);
    chk(irq, 1'b0);
    repeat (3) pulse(evt_t'{tx_err: 1'b1, default: '0});
    repeat (128) pulse(evt_t'{rx_err: 1'b1, default: '0});
    axi_rd(OFF_ERRCNT, 32'h0000_8018);
    axi_rd(OFF_INT_STAT, 32'h3);
    axi_wr(OFF_INT_EN, 32'h2);
    chk(irq, 1'b1);
    axi_wr(OFF_INT_CLR, 32'h2);
    axi_rd(OFF_INT_STAT, 32'h1);
    chk(irq, 1'b0);
    axi_wr(OFF_CTRL, 32'h2);
    chk(proc_active, 1'b0);
    pulse(evt_t'{tx_err: 1'b1, default: '0});
    axi_rd(OFF_ERRCNT, 32'h0000_8018);
    axi_wr(OFF_CTRL, 32'h3);
    chk(proc_active, 1'b1);
    axi_rd(OFF_ERRCNT, 32'h0000_8018);
    summarize();
  end
endmodule : test_can_ctrl_core
